// *** src/eeprom_pkg.sv ***
// Purpose: shared constants and types for the two-wire eeprom slave
// Assumes: 100 MHz system clock, bus pins sampled by that clock
// Notes:   all counts derive from times in their own units
`default_nettype none
package eeprom_pkg;
  localparam int          ARRAY_BYTES   = 4096;
  localparam int          PAGE_BYTES    = 32;
  localparam int          ADDR_W        = 12;
  localparam int          PAGE_W        = 5;
  localparam logic [3:0]  CODE_ARRAY    = 4'ha;
  localparam logic [3:0]  CODE_IDPAGE   = 4'hb;
  localparam int          LOCK_ADDR_BIT = 2;   // bit of the high address byte (address bit 10)
  localparam int          LOCK_DATA_BIT = 1;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;
  localparam int          MCLK_MHZ      = 100;
  localparam int          WRITE_TIME_US = 5000;
  localparam int          WRITE_CYCLES  = WRITE_TIME_US * MCLK_MHZ;  // longest time, exact product, no rounding
  localparam int          TIMER_W       = 19;
  localparam logic        SDA_OE_N_RST  = 1'b1;
  localparam logic        BUSY_RST      = 1'b0;
  localparam logic        LOCK_RST      = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_DEV   = 3'h1,
    ST_ADRH  = 3'h3,
    ST_ADRL  = 3'h2,
    ST_WDAT  = 3'h6,
    ST_RDAT  = 3'h7
  } bus_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_s;

  typedef struct packed {
    logic       wp;
    logic [2:0] hw_sel;
  } strap_pins_s;
endpackage
`default_nettype wire

// *** src/two_wire_eeprom_slave.sv ***
// Purpose: two-wire eeprom slave, 4096 bytes, 32-byte pages, lockable id page
// Assumes: scl, sda, wp and select pins are asynchronous; i_reset is power-on reset
// Notes:   scl is oversampled by i_mclk, no edge of scl clocks any flip-flop
// Contract
// - store 4096 bytes of eight bits, grouped in 32-byte pages.
// - partial page writes program only the bytes actually received.
// - self-timed programming after write stop, finished within 5 ms.
// - ignore all bus traffic while power-on reset is active.
// - leaving power-on reset resets state machine into standby, no write triggered.
// - entering power-on reset drops back to standby, bus ignored.
// - on stop enter standby unless programming runs; finish programming first.
// - extra 32-byte id page, writable, lockable permanently read-only; here the lock clears on power-on reset.
// - write-protect high blocks every change to the main array.
// - write-protect low lets main array writes proceed normally.
// - unconnected select inputs count as logic zero; here they must be tied low outside.
// - three select inputs choose which of 8 devices answers.
// - data line only pulled low or released, open drain.
// - answer only select code 1010 plus matching select bits; last bit read; code 1011 is answered too.
// - page write increments five low address bits, wrapping inside the page.
// - withhold select acknowledge while programming is in progress.
// - select code 1011 directs writes and lock to the id page.
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_slave #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_wp,
  input  wire logic i_hw_select_bit0,
  input  wire logic i_hw_select_bit1,
  input  wire logic i_hw_select_bit2,
  output var  logic o_sda_out,
  output var  logic o_sda_oe_n,
  output var  logic o_busy
);
  eeprom_pkg::bus_pins_s             pin_meta_reg;
  eeprom_pkg::bus_pins_s             pin_sync_reg;
  eeprom_pkg::bus_pins_s             pin_prev_reg;
  eeprom_pkg::strap_pins_s           strap_meta_reg;
  eeprom_pkg::strap_pins_s           strap_sync_reg;
  eeprom_pkg::bus_state_e            state_reg;
  logic [3:0]                        bit_cnt_reg;
  logic [7:0]                        shift_reg;
  logic [7:0]                        tx_reg;
  logic [3:0]                        addr_hi_reg;
  logic                              lock_addr_reg;
  logic [eeprom_pkg::ADDR_W-1:0]     addr_reg;
  logic                              id_sel_reg;
  logic [eeprom_pkg::PAGE_BYTES-1:0] valid_reg;
  logic                              lock_pend_reg;
  logic                              id_locked_reg;
  logic [eeprom_pkg::TIMER_W-1:0]    timer_reg;
  logic [7:0]                        page_buf [eeprom_pkg::PAGE_BYTES];
  logic [7:0]                        array_mem [eeprom_pkg::ARRAY_BYTES];
  logic [7:0]                        id_mem [eeprom_pkg::PAGE_BYTES];
  logic                              start_det;
  logic                              stop_det;
  logic                              scl_rise;
  logic                              scl_fall;
  logic                              dev_match;
  logic                              byte_done;
  logic                              write_done;
  logic                              commit_go;
  logic [7:0]                        rd_byte;

  // plain two-flop synchronisers; the second stage and a third bus stage for edge detection are read
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta_reg   <= '{scl: 1'b1, sda: 1'b1};
      pin_sync_reg   <= '{scl: 1'b1, sda: 1'b1};
      pin_prev_reg   <= '{scl: 1'b1, sda: 1'b1};
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      pin_meta_reg   <= '{scl: i_scl, sda: i_sda};
      pin_sync_reg   <= pin_meta_reg;
      pin_prev_reg   <= pin_sync_reg;
      strap_meta_reg <= '{wp: i_wp, hw_sel: {i_hw_select_bit2, i_hw_select_bit1, i_hw_select_bit0}};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // start and stop are sda edges while scl stays high
  assign start_det = pin_sync_reg.scl & pin_prev_reg.scl & pin_prev_reg.sda & ~pin_sync_reg.sda;
  assign stop_det  = pin_sync_reg.scl & pin_prev_reg.scl & ~pin_prev_reg.sda & pin_sync_reg.sda;
  assign scl_rise  = pin_sync_reg.scl & ~pin_prev_reg.scl;
  assign scl_fall  = ~pin_sync_reg.scl & pin_prev_reg.scl;
  assign byte_done = scl_fall & (bit_cnt_reg == eeprom_pkg::ACK_SLOT);

  // floating select pins must be tied low outside; a bare float cannot be seen here
  assign dev_match = (shift_reg[7:4] == eeprom_pkg::CODE_ARRAY ||
                      shift_reg[7:4] == eeprom_pkg::CODE_IDPAGE) &&
                     (shift_reg[3:1] == strap_sync_reg.hw_sel) &&
                     !o_busy;

  assign rd_byte = id_sel_reg ? id_mem[addr_reg[eeprom_pkg::PAGE_W-1:0]] : array_mem[addr_reg];
  assign write_done = o_busy && (timer_reg == eeprom_pkg::TIMER_W'(WRITE_CYCLES - 1));
  // programming only starts on a stop after data, never at power-up
  assign commit_go = stop_det && (state_reg == eeprom_pkg::ST_WDAT) &&
                     (|valid_reg || lock_pend_reg) && !o_busy;

  // protocol state, bit count and receive shift
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_reg   <= eeprom_pkg::ST_IDLE;
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end else if (start_det) begin
      state_reg   <= eeprom_pkg::ST_DEV;
      bit_cnt_reg <= '0;
    end else if (stop_det) begin
      state_reg   <= eeprom_pkg::ST_IDLE;
    end else if (state_reg != eeprom_pkg::ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_reg != eeprom_pkg::ACK_SLOT) begin
          shift_reg   <= {shift_reg[6:0], pin_sync_reg.sda};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else begin
          bit_cnt_reg <= '0;
          if (state_reg == eeprom_pkg::ST_RDAT && pin_sync_reg.sda) begin
            state_reg <= eeprom_pkg::ST_IDLE;                          // master declined more data
          end
        end
      end else if (byte_done) begin
        case (state_reg)
          eeprom_pkg::ST_DEV: begin
            if (!dev_match) begin
              state_reg <= eeprom_pkg::ST_IDLE;
            end else if (shift_reg[0]) begin
              state_reg <= eeprom_pkg::ST_RDAT;
            end else begin
              state_reg <= eeprom_pkg::ST_ADRH;
            end
          end
          eeprom_pkg::ST_ADRH: state_reg <= eeprom_pkg::ST_ADRL;
          eeprom_pkg::ST_ADRL: state_reg <= eeprom_pkg::ST_WDAT;
          default: state_reg <= state_reg;
        endcase
      end
    end
  end

  // address pointer, target select and page buffer
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      addr_reg      <= '0;
      addr_hi_reg   <= '0;
      lock_addr_reg <= 1'b0;
      id_sel_reg    <= 1'b0;
      valid_reg     <= '0;
      lock_pend_reg <= 1'b0;
      tx_reg        <= '0;
    end else if (byte_done && state_reg == eeprom_pkg::ST_DEV && dev_match) begin
      id_sel_reg <= (shift_reg[7:4] == eeprom_pkg::CODE_IDPAGE);
      tx_reg     <= (shift_reg[7:4] == eeprom_pkg::CODE_IDPAGE) ?
                    id_mem[addr_reg[eeprom_pkg::PAGE_W-1:0]] : array_mem[addr_reg];
    end else if (byte_done && state_reg == eeprom_pkg::ST_ADRH) begin
      addr_hi_reg   <= shift_reg[3:0];
      lock_addr_reg <= shift_reg[eeprom_pkg::LOCK_ADDR_BIT];
    end else if (byte_done && state_reg == eeprom_pkg::ST_ADRL) begin
      addr_reg      <= {addr_hi_reg, shift_reg};
      valid_reg     <= '0;
      lock_pend_reg <= 1'b0;
    end else if (byte_done && state_reg == eeprom_pkg::ST_WDAT) begin
      if (id_sel_reg && lock_addr_reg) begin
        lock_pend_reg <= shift_reg[eeprom_pkg::LOCK_DATA_BIT] & ~id_locked_reg;
      end else if (!(id_sel_reg && id_locked_reg) &&
                   !(!id_sel_reg && strap_sync_reg.wp)) begin
        valid_reg[addr_reg[eeprom_pkg::PAGE_W-1:0]] <= 1'b1;
      end
      // low five bits wrap inside the page; the rest stay put
      addr_reg[eeprom_pkg::PAGE_W-1:0] <= addr_reg[eeprom_pkg::PAGE_W-1:0] + 5'h1;
    end else if (byte_done && state_reg == eeprom_pkg::ST_RDAT) begin
      addr_reg <= addr_reg + 12'h001;
    end else if (scl_rise && state_reg == eeprom_pkg::ST_RDAT &&
                 bit_cnt_reg == eeprom_pkg::ACK_SLOT && !pin_sync_reg.sda) begin
      tx_reg <= rd_byte;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (byte_done && state_reg == eeprom_pkg::ST_WDAT) begin
      page_buf[addr_reg[eeprom_pkg::PAGE_W-1:0]] <= shift_reg;
    end
  end

  // self-timed programming: count out the cycle, then commit at its end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_busy    <= eeprom_pkg::BUSY_RST;
      timer_reg <= '0;
    end else if (commit_go) begin
      o_busy    <= 1'b1;
      timer_reg <= '0;
    end else if (write_done) begin
      o_busy    <= 1'b0;
    end else if (o_busy) begin
      timer_reg <= timer_reg + eeprom_pkg::TIMER_W'(1);
    end
  end

  // only received bytes of the page are programmed; untouched bytes keep their value
  always_ff @(posedge i_mclk) begin
    if (write_done) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (valid_reg[i] && id_sel_reg) begin
          id_mem[i] <= page_buf[i];
        end else if (valid_reg[i]) begin
          array_mem[{addr_reg[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W], 5'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // lock flag is meant as nonvolatile; here it lives until power-on reset
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      id_locked_reg <= eeprom_pkg::LOCK_RST;
    end else if (write_done && lock_pend_reg) begin
      id_locked_reg <= 1'b1;
    end
  end

  // open-drain data: output level is always low, only the enable moves
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_sda_out  <= 1'b0;
      o_sda_oe_n <= eeprom_pkg::SDA_OE_N_RST;
    end else if (start_det || stop_det) begin
      o_sda_oe_n <= 1'b1;
    end else if (byte_done) begin
      case (state_reg)
        eeprom_pkg::ST_DEV:  o_sda_oe_n <= ~dev_match;
        eeprom_pkg::ST_ADRH: o_sda_oe_n <= 1'b0;
        eeprom_pkg::ST_ADRL: o_sda_oe_n <= 1'b0;
        eeprom_pkg::ST_WDAT: o_sda_oe_n <= id_sel_reg & id_locked_reg & ~lock_addr_reg;
        default:             o_sda_oe_n <= 1'b1;                       // master acks read data
      endcase
    end else if (scl_fall && state_reg == eeprom_pkg::ST_RDAT) begin
      o_sda_oe_n <= tx_reg[~bit_cnt_reg[2:0]];
    end else if (scl_fall) begin
      o_sda_oe_n <= 1'b1;
    end
  end
endmodule // two_wire_eeprom_slave
`default_nettype wire

// *** testbench/two_wire_eeprom_slave_assertions.sv ***
// Purpose: port checker for the two-wire eeprom slave
// Assumes: WRITE_CYCLES equals that of the bound instance
// Notes:   one clock domain, so default clocking and disable
`timescale 1ns/10ps
`default_nettype none
module eeprom_slave_checker #(
  parameter int WRITE_CYCLES = 200
) (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_busy
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  int busy_cnt_reg;
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) busy_cnt_reg <= 0;
    else busy_cnt_reg <= o_busy ? busy_cnt_reg + 1 : 0;
  end
  sequence s_busy_hold;
    o_busy [*8];
  endsequence
  AST_OPEN_DRAIN: assert property (o_sda_out == 1'b0)
    else $error("sda output not low");
  AST_RELEASE_IDLE: assert property ($fell(i_reset) |-> o_sda_oe_n && !o_busy)
    else $error("not idle after reset");
  AST_BUSY_AFTER_STOP: assert property ($rose(o_busy) |-> i_scl && i_sda)
    else $error("busy rose without stop");
  AST_BUSY_LENGTH: assert property ($fell(o_busy) |-> busy_cnt_reg >= WRITE_CYCLES - 1 &&
    busy_cnt_reg <= WRITE_CYCLES + 1) else $error("busy length wrong");
  AST_BUSY_HOLDS: assert property ($rose(o_busy) |-> s_busy_hold)
    else $error("busy dropped early");
  AST_QUIET_BUSY: assert property (o_busy |-> o_sda_oe_n)
    else $error("sda driven while busy");
  AST_DRIVE_SCL_LOW: assert property ($fell(o_sda_oe_n) |-> !i_scl)
    else $error("sda pulled while scl high");
  AST_ACK_HOLD: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*4])
    else $error("sda pull too short");
endmodule // eeprom_slave_checker
bind two_wire_eeprom_slave eeprom_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));
`default_nettype wire

// *** testbench/two_wire_eeprom_slave_tb_top.sv ***
// Purpose: self-checking bench for the two-wire eeprom slave
// Assumes: WRITE_CYCLES cut to 200 mclk
// Notes:   straps at 3'h5, so select byte is 8'haa
`timescale 1ns/10ps
`default_nettype none
module two_wire_eeprom_slave_tb_top;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       wp = 1'b0;
  logic [2:0] sel = 3'h5;
  logic       scl, sda_low, sda_out, sda_oe_n, busy;
  wire logic  sda_w = ~sda_low & (sda_oe_n | sda_out);
  int         n_mismatch = 0;
  int         check_count = 0;
  int         fn;
  logic [7:0] rd[$];
  always #5 mclk = ~mclk;
  two_wire_eeprom_slave #(.WRITE_CYCLES(200)) u_dut (.i_mclk(mclk), .i_reset(reset), .i_scl(scl),
    .i_sda(sda_w), .i_wp(wp), .i_hw_select_bit0(sel[0]), .i_hw_select_bit1(sel[1]),
    .i_hw_select_bit2(sel[2]), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_busy(busy));
  two_wire_master_model u_master (.i_mclk(mclk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // fn: index of first nacked byte, -1 if none
  task automatic xfer(input logic [7:0] w[$], input int nrd);
    logic [7:0] rx;
    logic a;
    fn = -1;
    rd = {};
    u_master.start_cond();
    foreach (w[i]) begin
      u_master.byte_io(w[i], 1'b1, rx, a);
      if (a !== 1'b0 && fn < 0) fn = i;
    end
    if (nrd > 0) begin
      u_master.start_cond();
      u_master.byte_io(w[0] | 8'h01, 1'b1, rx, a);
      for (int j = 0; j < nrd; j++) begin
        u_master.byte_io(8'hff, 1'(j == nrd - 1), rx, a);
        rd.push_back(rx);
      end
    end
    u_master.stop_cond();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0) begin
      @(posedge mclk);
      if (++n > 400) begin
        n_mismatch++;
        $display("CHECK FAILED busy expected 0 seen %b", busy);
        tally_and_finish();
      end
    end
  endtask
  task automatic t_page_wrap();
    xfer({8'haa, 8'hf0, 8'h1f, 8'h11, 8'h22, 8'h33}, 0);
    chk("page acks", 8'hff, 8'(fn));
    chk("busy", 8'h01, {7'h0, busy});
    xfer({8'haa}, 0);
    chk("poll nack", 8'h00, 8'(fn));
    wait_idle();
    xfer({8'haa, 8'h00, 8'h00}, 2);
    chk("wrap byte0", 8'h22, rd[0]);
    chk("wrap byte1", 8'h33, rd[1]);
    xfer({8'haa, 8'h00, 8'h1f}, 1);
    chk("page end", 8'h11, rd[0]);
  endtask
  task automatic t_select();
    xfer({8'ha0}, 0);
    chk("strap mismatch", 8'h00, 8'(fn));
    xfer({8'h5a}, 0);
    chk("bad code", 8'h00, 8'(fn));
  endtask
  task automatic t_wp();
    xfer({8'haa, 8'h00, 8'h40, 8'h3c}, 0);
    chk("wp off busy", 8'h01, {7'h0, busy});
    wait_idle();
    @(posedge mclk) wp <= 1'b1;
    xfer({8'haa, 8'h00, 8'h40, 8'hc3}, 0);
    chk("wp acks", 8'hff, 8'(fn));
    chk("wp busy", 8'h00, {7'h0, busy});
    @(posedge mclk) wp <= 1'b0;
    xfer({8'haa, 8'h00, 8'h40}, 1);
    chk("wp data", 8'h3c, rd[0]);
  endtask
  task automatic t_idpage();
    xfer({8'hba, 8'h00, 8'h05, 8'h77}, 0);
    wait_idle();
    xfer({8'hba, 8'h00, 8'h05}, 1);
    chk("id data", 8'h77, rd[0]);
    xfer({8'hba, 8'h04, 8'h00, 8'h02}, 0);
    chk("lock acks", 8'hff, 8'(fn));
    wait_idle();
    xfer({8'hba, 8'h00, 8'h05, 8'h99}, 0);
    chk("locked nack", 8'h03, 8'(fn));
    xfer({8'hba, 8'h00, 8'h05}, 1);
    chk("locked data", 8'h77, rd[0]);
  endtask
  // second reset in mid-run cuts a running write, traffic while held
  task automatic t_por();
    xfer({8'haa, 8'h00, 8'h50, 8'h11}, 0);
    chk("pre-reset busy", 8'h01, {7'h0, busy});
    @(posedge mclk) reset <= 1'b1;
    xfer({8'haa, 8'h00, 8'h50, 8'h11}, 0);
    chk("reset nack", 8'h00, 8'(fn));
    chk("reset busy", 8'h00, {7'h0, busy});
    @(posedge mclk) reset <= 1'b0;
    repeat (4) @(posedge mclk);
    xfer({8'haa}, 0);
    chk("standby ack", 8'hff, 8'(fn));
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    t_page_wrap();
    t_select();
    t_wp();
    t_idpage();
    t_por();
    tally_and_finish();
  end
endmodule // two_wire_eeprom_slave_tb_top
`default_nettype wire

// *** testbench/two_wire_master_model.sv ***
// Purpose: two-wire bus master model
// Assumes: scl period 16 mclk, quarter phase 4 mclk
// Notes:   scl rests high between frames; released sda reads high
`timescale 1ns/10ps
`default_nettype none
module two_wire_master_model (
  input  wire logic i_mclk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic quarter();
    repeat (4) @(posedge i_mclk);
  endtask
  // sda only moves while scl is low
  task automatic bit_io(input logic b, output logic seen);
    o_sda_low <= ~b;
    quarter();
    o_scl <= 1'b1;
    quarter();
    seen = i_sda;
    quarter();
    o_scl <= 1'b0;
    quarter();
  endtask
  task automatic start_cond();
    o_sda_low <= 1'b0;
    quarter();
    o_scl <= 1'b1;
    quarter();
    o_sda_low <= 1'b1;
    quarter();
    o_scl <= 1'b0;
    quarter();
  endtask
  task automatic stop_cond();
    o_sda_low <= 1'b1;
    quarter();
    o_scl <= 1'b1;
    quarter();
    o_sda_low <= 1'b0;
    quarter();
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack);
  endtask
endmodule // two_wire_master_model
`default_nettype wire
